// ==== pkg/pga_serial_pkg.sv ====
// constants, types and decode helpers shared by the amplifier serial control block
`default_nettype none

package pga_serial_pkg;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int CTRL_W = 8;
  localparam int GAIN_W = 4;
  localparam int GAIN_VV_W = 5;
  localparam int COMP_W = 2;
  localparam int COMP_LEVELS = 4;
  localparam int GAIN_LSB = 0;
  localparam int PD_POS = 4;
  localparam int ZERO_POS = 5;
  localparam int COMP_LSB = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // link and buffering
  // ----------------------------------------------------------------
  localparam int PIN_W = 3;
  localparam logic [PIN_W-1:0] PIN_RESET = 3'h7;
  localparam int BIT_CNT_W = 3;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [COMP_W-1:0] comp;
    logic zero;
    logic power_down_bit;
    logic [GAIN_W-1:0] gain;
  } ctrl_word_s;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
  } link_pins_s;

  typedef enum logic {
    LINK_IDLE,
    LINK_SELECTED
  } link_state_e;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [GAIN_VV_W-1:0] gain_vv(input logic [GAIN_W-1:0] code);
    gain_vv = {1'b0, code} + 5'h01;
  endfunction

  function automatic logic [COMP_LEVELS-1:0] comp_sel(input logic [COMP_W-1:0] code);
    comp_sel = 4'h1 << code;
  endfunction

endpackage

`default_nettype wire

// ==== hw/pga_pin_sync.sv ====
// two-stage synchroniser for the serial link pins
`default_nettype none

module pga_pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s q;
  sync_s d;

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  // the first stage is read only by the second one
  always_comb begin
    d = q;
    if (i_ce) begin
      d.meta = i_async;
      d.stable = q.meta;
    end
  end

  // reset to idle-high levels so no false edge is seen at release
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      q.meta <= RESET_VAL;
      q.stable <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.stable;

endmodule

`default_nettype wire

// ==== hw/pga_word_fifo.sv ====
// first-word-fall-through fifo between the shift register and the holding register
`default_nettype none

module pga_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_s;

  fifo_s q;
  fifo_s d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] ptr);
    next_ptr = (ptr == LAST_PTR) ? '0 : ptr + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // handshake
  // ----------------------------------------------------------------
  assign o_in_ready = (q.count != DEPTH_C);
  assign o_out_valid = (q.count != '0);
  assign o_out_data = q.mem[q.rd_ptr];
  assign push = i_ce & i_in_valid & o_in_ready;
  assign pop = i_ce & i_out_ready & o_out_valid;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = i_in_data;
      d.wr_ptr = next_ptr(q.wr_ptr);
    end
    if (pop) begin
      d.rd_ptr = next_ptr(q.rd_ptr);
    end
    case ({push, pop})
      2'b10: d.count = q.count + 1'b1;
      2'b01: d.count = q.count - 1'b1;
      default: d.count = q.count;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fifo_fill_count: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (push && !pop) |=> (q.count == $past(q.count) + 1'b1))
    else $error("fifo count did not rise on push");

endmodule

`default_nettype wire

// ==== hw/pga_serial_control.sv ====
// serial control front end and held control word of the programmable-gain amplifier
//
// Behaviour
// - gain code 0..15 selects gain 1..16
// - compensation 00 most, 11 least
// - zeroing ties input to gain reference terminal
// - eight-bit shift register fed from data input
// - bits leaving shift register appear on output
// - shifting enabled after select falls, while low
// - one data bit per serial clock rise
// - words queue at select rise; holding register loads from fifo while i_update_en high
// - chain: output feeds next device's input
// - star: shared lines give identical words
// - control word reads zero after power-on
// - layout: comp, zero, power-down, gain
// - power-down wins, else zero bit zeroes input
// - power-up clears all control bits
`default_nettype none

module pga_serial_control
  import pga_serial_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_update_en,
  output logic o_sdo,
  output logic [CTRL_W-1:0] o_ctrl_word,
  output logic [GAIN_W-1:0] o_gain_code,
  output logic [GAIN_VV_W-1:0] o_gain_vv,
  output logic [COMP_W-1:0] o_comp_level,
  output logic [COMP_LEVELS-1:0] o_comp_sel,
  output logic o_power_down,
  output logic o_input_to_gain_reference_terminal,
  output logic o_input_from_pin,
  output logic o_word_ready,
  output logic o_partial_word
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    link_state_e state;
    logic cs_prev;
    logic sck_prev;
    logic [CTRL_W-1:0] shreg;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic partial;
    ctrl_word_s ctrl;
    logic [GAIN_VV_W-1:0] gain_vv;
    logic [COMP_LEVELS-1:0] comp_sel;
    logic pd;
    logic zero;
    logic from_pin;
    logic room;
  } state_s;

  state_s q;
  state_s d;

  link_pins_s pins_raw;
  link_pins_s pins_s;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic shift_en;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [CTRL_W-1:0] fifo_out_data;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // the link clock is only sampled; 20 MHz against a 400 ns link period
  // leaves four samples per half period for edge detection
  assign pins_raw = '{cs_n: i_cs_n, sck: i_sck, sdi: i_sdi};

  pga_pin_sync #(
    .WIDTH(PIN_W),
    .RESET_VAL(PIN_RESET)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  assign cs_fall = q.cs_prev & ~pins_s.cs_n;
  assign cs_rise = ~q.cs_prev & pins_s.cs_n;
  assign sck_rise = ~q.sck_prev & pins_s.sck;
  // a clock rise inside the select window only
  assign shift_en = (q.state == LINK_SELECTED) & sck_rise & ~pins_s.cs_n;

  // the finished word is handed to the fifo at the select rise
  assign fifo_in_valid = i_ce & (q.state == LINK_SELECTED) & cs_rise;

  // ----------------------------------------------------------------
  // word buffer
  // ----------------------------------------------------------------
  // a full fifo drops the word; o_word_ready warns the system side
  pga_word_fifo #(
    .WIDTH(CTRL_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_word_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_in_valid(fifo_in_valid),
    .i_in_data(q.shreg),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(i_update_en)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (i_ce) begin
      d.cs_prev = pins_s.cs_n;
      d.sck_prev = pins_s.sck;
      d.room = fifo_in_ready;
      case (q.state)
        LINK_IDLE: begin
          if (cs_fall) begin
            d.state = LINK_SELECTED;
            d.bit_cnt = '0;
          end
        end
        LINK_SELECTED: begin
          if (cs_rise) begin
            d.state = LINK_IDLE;
            d.partial = (q.bit_cnt != '0);
          end else if (shift_en) begin
            // msb first; the old msb moves out to the next device
            d.shreg = {q.shreg[CTRL_W-2:0], pins_s.sdi};
            d.bit_cnt = q.bit_cnt + 1'b1;
          end
        end
        default: begin
          d.state = LINK_IDLE;
        end
      endcase
      // drained words become the active settings, one per cycle
      if (fifo_out_valid && i_update_en) begin
        d.ctrl = ctrl_word_s'(fifo_out_data);
      end
      d.gain_vv = gain_vv(d.ctrl.gain);
      d.comp_sel = comp_sel(d.ctrl.comp);
      d.pd = d.ctrl.power_down_bit;
      d.zero = d.ctrl.zero & ~d.ctrl.power_down_bit;
      d.from_pin = ~d.ctrl.zero & ~d.ctrl.power_down_bit;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset stands for power-on: all control bits clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      q.state <= LINK_IDLE;
      q.cs_prev <= 1'b1;
      q.sck_prev <= 1'b1;
      q.shreg <= CTRL_RESET;
      q.bit_cnt <= '0;
      q.partial <= 1'b0;
      q.ctrl <= ctrl_word_s'(CTRL_RESET);
      q.gain_vv <= gain_vv(CTRL_RESET[GAIN_LSB +: GAIN_W]);
      q.comp_sel <= comp_sel(CTRL_RESET[COMP_LSB +: COMP_W]);
      q.pd <= CTRL_RESET[PD_POS];
      q.zero <= 1'b0;
      q.from_pin <= 1'b1;
      q.room <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // star wiring needs nothing extra: equal inputs give equal words
  assign o_sdo = q.shreg[CTRL_W-1];
  assign o_ctrl_word = q.ctrl;
  assign o_gain_code = q.ctrl.gain;
  assign o_gain_vv = q.gain_vv;
  assign o_comp_level = q.ctrl.comp;
  assign o_comp_sel = q.comp_sel;
  assign o_power_down = q.pd;
  assign o_input_to_gain_reference_terminal = q.zero;
  assign o_input_from_pin = q.from_pin;
  assign o_word_ready = q.room;
  assign o_partial_word = q.partial;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_shift_sample_in: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && shift_en && !cs_rise) |=> (q.shreg == {$past(q.shreg[CTRL_W-2:0]), $past(pins_s.sdi)}))
    else $error("serial bit not shifted in on clock rise");

  a_sdo_passes_msb: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && shift_en && !cs_rise) |=> (o_sdo == $past(q.shreg[CTRL_W-2])))
    else $error("serial output does not carry the outgoing bit");

  a_idle_no_shift: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (q.state == LINK_IDLE) |=> $stable(q.shreg))
    else $error("shift register moved while not selected");

  a_select_on_fall: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && q.state == LINK_IDLE && cs_fall) |=> ((q.state == LINK_SELECTED) && (q.bit_cnt == '0)))
    else $error("select fall did not open the shift window");

  a_hold_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !fifo_out_valid |=> $stable(o_ctrl_word))
    else $error("active settings changed with no word pending");

  a_word_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (fifo_in_valid && !fifo_out_valid && fifo_in_ready) ##1 (i_ce && i_update_en)
    |=> (o_ctrl_word == $past(q.shreg, 2)))
    else $error("shifted word not moved to holding register");

  a_gain_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_gain_vv == ({1'b0, o_ctrl_word[GAIN_LSB +: GAIN_W]} + 5'h01))
    else $error("gain decode wrong");

  a_comp_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_comp_level == o_ctrl_word[COMP_LSB +: COMP_W]) && (o_comp_sel == (4'h1 << o_comp_level)))
    else $error("compensation decode wrong");

  a_pd_priority: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_ctrl_word[PD_POS] |-> (o_power_down && !o_input_to_gain_reference_terminal && !o_input_from_pin))
    else $error("power-down does not override other modes");

  a_zero_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!o_ctrl_word[PD_POS] && o_ctrl_word[ZERO_POS]) |-> (o_input_to_gain_reference_terminal && !o_input_from_pin))
    else $error("zeroing bit did not route input to reference");

  a_reset_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> (o_ctrl_word == CTRL_RESET && o_gain_vv == 5'h01 && !o_power_down))
    else $error("control word not clear after reset");

  a_partial_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (fifo_in_valid && q.bit_cnt != '0) |=> o_partial_word)
    else $error("short word not flagged");

  a_partial_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (fifo_in_valid && q.bit_cnt == '0) |=> !o_partial_word)
    else $error("whole word flagged as short");

  // a low enable must hold even pending words back from the settings
  a_ce_freeze: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_ce |=> ($stable(o_ctrl_word) && $stable(o_sdo) && $stable(o_word_ready)))
    else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ==== testbench/pga_host_model.sv ====
// host model driving the serial control pins of the amplifier
`default_nettype none

module pga_host_model (
  input wire logic i_clk_sys,
  input wire logic i_sdo,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] rx;

  // ----------------------------------------------------------------
  // idle lines
  // ----------------------------------------------------------------
  // select and clock high from time zero so the power-up clear holds
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b1;
    o_sdi = 1'b0;
    rx = 16'h0000;
  end

  // ----------------------------------------------------------------
  // transfers
  // ----------------------------------------------------------------
  // half a link clock period is four system clocks
  task automatic step();
    repeat (4) @(posedge i_clk_sys);
    #2;
  endtask

  task automatic idle_pulses(input int n);
    for (int k = 0; k < n; k++) begin
      o_sck = 1'b0;
      o_sdi = ~o_sdi;
      step();
      o_sck = 1'b1;
      step();
    end
  endtask

  task automatic write_bits(input logic [15:0] d, input int n);
    o_cs_n = 1'b0;
    step();
    for (int k = n - 1; k >= 0; k--) begin
      o_sck = 1'b0;
      o_sdi = d[k];
      step();
      o_sck = 1'b1;
      step();
      rx = {rx[14:0], i_sdo};
    end
    o_cs_n = 1'b1;
    step();
    // a stale bit would hide a design that samples outside the window
    o_sdi = ~o_sdi;
    step();
  endtask
endmodule

`default_nettype wire

// ==== testbench/pga_serial_control_tb.sv ====
// self-checking bench for the amplifier serial control block
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module pga_serial_control_tb
  import pga_serial_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DEPTH = 4;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce;
  logic update_en;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic [CTRL_W-1:0] ctrl_word;
  logic [GAIN_W-1:0] gain_code;
  logic [GAIN_VV_W-1:0] gain_vv;
  logic [COMP_W-1:0] comp_level;
  logic [COMP_LEVELS-1:0] comp_sel;
  logic power_down;
  logic to_grt;
  logic from_pin;
  logic word_ready;
  logic partial_word;
  logic [7:0] v;
  logic [7:0] w [DEPTH+1];
  int err_total = 0;
  int n_checks = 0;

  // ----------------------------------------------------------------
  // clock, instances, verdict
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  pga_serial_control #(.FIFO_DEPTH_P(DEPTH)) i_dut (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ce(ce), .i_cs_n(cs_n), .i_sck(sck), .i_sdi(sdi),
    .i_update_en(update_en), .o_sdo(sdo), .o_ctrl_word(ctrl_word), .o_gain_code(gain_code),
    .o_gain_vv(gain_vv), .o_comp_level(comp_level), .o_comp_sel(comp_sel), .o_power_down(power_down),
    .o_input_to_gain_reference_terminal(to_grt), .o_input_from_pin(from_pin),
    .o_word_ready(word_ready), .o_partial_word(partial_word)
  );

  pga_host_model i_host (
    .i_clk_sys(clk_sys), .i_sdo(sdo), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi)
  );

  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // low gains go unstable with little compensation
  function automatic logic [1:0] host_comp(input logic [3:0] g);
    if (g < 4'h5) return 2'h0;
    if (g < 4'ha) return {1'b0, g[0]};
    if (g < 4'hf) return 2'(g % 4'h3);
    return 2'h3;
  endfunction

  task automatic check_word(input logic [7:0] e);
    `CHK("ctrl_word", e, ctrl_word)
    `CHK("gain_code", e[3:0], gain_code)
    `CHK("gain_vv", {1'b0, e[3:0]} + 5'h01, gain_vv)
    `CHK("comp_level", e[7:6], comp_level)
    `CHK("comp_sel", 4'h1 << e[7:6], comp_sel)
    `CHK("power_down", e[4], power_down)
    `CHK("zeroing", e[5] & ~e[4], to_grt)
    `CHK("from_pin", ~e[5] & ~e[4], from_pin)
  endtask

  task automatic write_word(input logic [7:0] e);
    i_host.write_bits({8'h00, e}, 8);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    ce = 1'b1;
    update_en = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #2;
    check_word(8'h00);
    `CHK("sdo", 1'b0, sdo)
    `CHK("word_ready", 1'b1, word_ready)
    `CHK("partial", 1'b0, partial_word)
    i_host.idle_pulses(3);
    for (int i = 0; i < 16; i++) begin
      v = {host_comp(4'(i)), i[3], i[2], 4'(i)};
      write_word(v);
      check_word(v);
      `CHK("partial", 1'b0, partial_word)
    end
    fork
      write_word(8'h8a);
      begin
        repeat (40) @(posedge clk_sys);
        #2;
        `CHK("held", v, ctrl_word)
      end
    join
    check_word(8'h8a);
    i_host.write_bits(16'h0501, 16);
    check_word(8'h01);
    `CHK("sdo_stream", 8'h05, i_host.rx[8:1])
    // eight clock pulses with select high would shift in the toggled data and leave its first 1 on the output
    i_host.idle_pulses(8);
    `CHK("idle_sdo", 1'b0, sdo)
    i_host.write_bits(16'h0016, 5);
    `CHK("partial", 1'b1, partial_word)
    `CHK("short_word", 8'h36, ctrl_word)
    write_word(8'h00);
    `CHK("partial", 1'b0, partial_word)
    update_en = 1'b0;
    for (int k = 0; k <= DEPTH; k++) begin
      w[k] = 8'h10 + 8'(k);
      write_word(w[k]);
    end
    `CHK("word_ready", 1'b0, word_ready)
    `CHK("held", 8'h00, ctrl_word)
    // a low enable holds pending words back
    ce = 1'b0;
    update_en = 1'b1;
    repeat (4) @(posedge clk_sys);
    #2;
    `CHK("frozen", 8'h00, ctrl_word)
    `CHK("frozen_ready", 1'b0, word_ready)
    ce = 1'b1;
    update_en = 1'b0;
    @(posedge clk_sys);
    #2;
    for (int k = 0; k <= DEPTH; k++) begin
      update_en = 1'b1;
      @(posedge clk_sys);
      #2 update_en = 1'b0;
      repeat (2) @(posedge clk_sys);
      #2;
      `CHK("drain", w[(k < DEPTH) ? k : DEPTH - 1], ctrl_word)
    end
    `CHK("word_ready", 1'b1, word_ready)
    // a second power-on must clear a word that is not zero
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2;
    check_word(8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire
